// >>> dv/sssc_channel_properties.sv
`timescale 1ns/100ps
module sssc_channel_properties
  import sssc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Configuration
  input wire logic [3:0] cfg_width,
  input wire logic [5:0] cfg_mult,
  input wire logic align_bypass,
  // Watched ports
  input wire logic tx_link_clk,
  input wire logic tx_data_pin,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [SSSC_MAXW-1:0] rx_word,
  input wire logic rx_valid,
  input wire logic rx_locked,
  input wire logic cfg_error
);
  // ****
  // Channel checks
  // ****
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic bad_w;
  assign bad_w = cfg_width == 4'h0 || cfg_width == 4'h3 || cfg_width > SSSC_J_MAX;
  sequence bad_cfg;
    bad_w || cfg_mult < SSSC_W_MIN || cfg_mult > SSSC_W_MAX;
  endsequence
  sequence good_cfg;
    !bad_w && cfg_mult >= SSSC_W_MIN && cfg_mult <= SSSC_W_MAX;
  endsequence
  sequence tx_take;
    tx_ready && tx_valid;
  endsequence
  tx_clk_a: assert property (!$past(sys_rst) |-> tx_link_clk != $past(tx_link_clk))
    else $error("tx clock stalled");
  tx_bit_a: assert property ($changed(tx_data_pin) |-> $past(tx_link_clk))
    else $error("tx bit changed early");
  tx_gap_a: assert property (tx_take |=> !tx_ready [*2])
    else $error("tx ready too soon");
  cfg_bad_a: assert property (bad_cfg [*3] |-> cfg_error)
    else $error("bad config not flagged");
  cfg_good_a: assert property (good_cfg [*3] |-> !cfg_error)
    else $error("good config flagged");
  rx_upper_a: assert property (rx_valid && !bad_w |-> (rx_word >> cfg_width) == '0)
    else $error("rx upper bits set");
  bypass_lock_a: assert property (align_bypass [*5] |-> rx_locked)
    else $error("bypass not locked");
  no_sample_a: assert property (cfg_error [*8] |-> !rx_valid)
    else $error("word under bad config");
  rx_hold_a: assert property (!rx_valid && !$past(sys_rst) |-> $stable(rx_word))
    else $error("rx word changed");
endmodule
bind sssc_channel sssc_channel_properties u_props (.clk_sys, .sys_rst, .cfg_width,
  .cfg_mult, .align_bypass, .tx_link_clk, .tx_data_pin, .tx_valid, .tx_ready,
  .rx_word, .rx_valid, .rx_locked, .cfg_error);

// >>> dv/sssc_channel_tb.sv
`timescale 1ns/100ps
module sssc_channel_tb
  import sssc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] cfg_width = SSSC_J_RST;
  logic [5:0] cfg_mult = SSSC_W_RST;
  logic align_bypass = 1'b1;
  logic [SSSC_MAXW-1:0] tx_word = '0;
  logic tx_valid = 1'b0;
  logic rx_link_clk, rx_data_pin, tx_link_clk, tx_data_pin;
  logic tx_ready, rx_valid, rx_locked, cfg_error;
  logic [SSSC_MAXW-1:0] rx_word, tx_hist;
  logic [SSSC_MAXW-1:0] rxq[$];
  int fail_count = 0;
  int checks_done = 0;
  always #20 clk_sys = ~clk_sys;
  sssc_channel dut (.clk_sys, .sys_rst, .cfg_width, .cfg_mult, .align_bypass,
    .rx_link_clk, .rx_data_pin, .tx_link_clk, .tx_data_pin, .tx_word, .tx_valid,
    .tx_ready, .rx_word, .rx_valid, .rx_locked, .cfg_error);
  sssc_far_end far (.clk_sys, .rx_link_clk, .rx_data_pin, .tx_link_clk,
    .tx_data_pin, .tx_hist);
  always @(negedge clk_sys) begin
    if (rx_valid === 1'b1) begin
      rxq.push_back(rx_word);
    end
  end
  // ****
  // Helpers
  // ****
  task automatic chk_w(input string what, input logic [9:0] exp, input logic [9:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_f(input string what, input logic exp, input logic got);
    chk_w(what, {9'h0, exp}, {9'h0, got});
  endtask
  task automatic restart(input logic [3:0] w, input logic byp);
    @(negedge clk_sys) sys_rst = 1'b1;
    cfg_width = w;
    cfg_mult = 6'h01;
    align_bypass = byp;
    rxq.delete();
    repeat (16) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask
  function automatic logic [9:0] msk(input logic [3:0] w);
    return (10'h001 << w) - 10'h001;
  endfunction
  // ****
  // Scenarios
  // ****
  task automatic t_cfg();
    logic [3:0] w[7] = '{4'h3, 4'hB, 4'h0, 4'hA, 4'hA, 4'hA, 4'h4};
    logic [5:0] m[7] = '{6'h01, 6'h01, 6'h01, 6'h00, 6'h21, 6'h20, 6'h01};
    restart(4'h3, 1'b1);
    far.send(10'h00F, 4);
    repeat (12) @(negedge clk_sys);
    chk_w("bad cfg words", 10'h000, 10'(rxq.size()));
    for (int i = 0; i < 7; i++) begin
      cfg_width = w[i];
      cfg_mult = m[i];
      repeat (5) @(negedge clk_sys);
      chk_f("cfg error", i < 5, cfg_error);
    end
  endtask
  task automatic t_small();
    restart(4'h1, 1'b1);
    far.send(10'h00B, 4);
    repeat (12) @(negedge clk_sys);
    for (int i = 0; i < 4; i++) begin
      chk_w("width one", 10'(4'hB >> (3 - i)) & 10'h001, rxq[i]);
    end
    restart(4'h2, 1'b1);
    chk_f("width two", 1'b0, cfg_error);
  endtask
  task automatic t_rx(input logic byp);
    logic [9:0] a;
    for (logic [3:0] w = 4'h4; w <= 4'hA; w++) begin
      a = 10'h35A & msk(w);
      restart(w, byp);
      if (!byp) begin
        far.send(10'h000, 10);
      end
      far.send(a, w);
      far.send(~a & msk(w), w);
      far.send(a, w);
      repeat (12) @(negedge clk_sys);
      chk_f("locked", 1'b1, rx_locked);
      if (byp) begin
        chk_w("word a", a, rxq[0]);
        chk_w("word b", ~a & msk(w), rxq[1]);
        chk_w("words", 10'h003, 10'(rxq.size()));
      end else begin
        chk_f("aligned words", 1'b1, rxq.size() >= 2);
      end
    end
  endtask
  task automatic t_switch();
    restart(4'h8, 1'b1);
    far.send(10'h0A5, 8);
    align_bypass = 1'b0;
    far.send(10'h0C3, 8);
    far.send(10'h03C, 8);
    far.send(10'h0F0, 8);
    align_bypass = 1'b1;
    far.send(10'h096, 8);
    repeat (12) @(negedge clk_sys);
    chk_f("locked", 1'b1, rx_locked);
    chk_w("after switch", 10'h096, rxq[$]);
  endtask
  task automatic t_tx();
    logic [9:0] d;
    for (logic [3:0] w = 4'h4; w <= 4'hA; w++) begin
      restart(w, 1'b1);
      for (int k = 0; k < 2; k++) begin
        d = (k ? 10'h2C9 : 10'h136) & msk(w);
        tx_word = d;
        tx_valid = 1'b1;
        for (int n = 0; n < 40 && tx_ready !== 1'b1; n++) @(negedge clk_sys);
        @(negedge clk_sys) tx_valid = 1'b0;
        for (int n = 0; n < 40 && tx_ready !== 1'b1; n++) @(negedge clk_sys);
        chk_f("tx ready", 1'b1, tx_ready);
        chk_w("tx bits", d, tx_hist & msk(w));
      end
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    fail_count++;
    wrap_up();
  end
  initial begin
    t_cfg();
    t_small();
    t_rx(1'b1);
    t_rx(1'b0);
    t_switch();
    t_tx();
    wrap_up();
  end
endmodule

// >>> dv/sssc_far_end.sv
`timescale 1ns/100ps
module sssc_far_end
  import sssc_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Toward receiver
  output logic rx_link_clk,
  output logic rx_data_pin,
  // From transmitter
  input wire logic tx_link_clk,
  input wire logic tx_data_pin,
  output logic [SSSC_MAXW-1:0] tx_hist
);
  // ****
  // Remote link ends
  // ****
  initial begin
    rx_link_clk = 1'b0;
    rx_data_pin = 1'b0;
  end
  task automatic send(input logic [SSSC_MAXW-1:0] bits, input int n);
    #13;
    for (int i = n - 1; i >= 0; i--) begin
      rx_data_pin = bits[i];
      #160 rx_link_clk = 1'b1;
      #160 rx_link_clk = 1'b0;
    end
    rx_data_pin = ~rx_data_pin;
  endtask
  always_ff @(posedge clk_sys) begin
    if (tx_link_clk) begin
      tx_hist <= {tx_hist[SSSC_MAXW-2:0], tx_data_pin};
    end
  end
endmodule

// >>> logic/sssc_channel.sv
// Overview of operation
// [R1] Channel carries serial data plus a forwarded link clock, up to 1 Gbps.
// [R2] Receive sampling rate multiplies link clock by integer factor one to 32.
// [R3] Parallel width selectable four to ten, independent of multiply factor.
// [R4] Phase alignment path works for every supported parallel width.
// [R5] Factor one bypasses serdes; factor two uses double-rate cell registers. Code applies these to width one and two instead.
// [R6] Receiver stages: phase select, deserializer, synchronizer, realigner.
// [R7] Phase alignment can be bypassed; basic reception still works.
// [R8] Core control input switches aligned and bypass paths at run time.
// [R9] Elastic buffer moves words into core domain, none lost or doubled.
`timescale 1ns/100ps
module sssc_channel
  import sssc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Configuration
  input wire logic [3:0] cfg_width,
  input wire logic [5:0] cfg_mult,
  input wire logic align_bypass,
  // Link receive pins
  input wire logic rx_link_clk,
  input wire logic rx_data_pin,
  // Link transmit pins
  output logic tx_link_clk,
  output logic tx_data_pin,
  // Core transmit word
  input wire logic [SSSC_MAXW-1:0] tx_word,
  input wire logic tx_valid,
  output logic tx_ready,
  // Core receive word
  output logic [SSSC_MAXW-1:0] rx_word,
  output logic rx_valid,
  output logic rx_locked,
  output logic cfg_error
);

  // ****************************************************************
  // Configuration check
  // ****************************************************************
  logic [3:0] width;
  logic [5:0] mult;
  logic cfg_ok;
  // [R3] Width range check
  always_comb begin
    cfg_ok = (cfg_mult >= SSSC_W_MIN) && (cfg_mult <= SSSC_W_MAX) &&
      ((cfg_width == SSSC_J_ONE) || (cfg_width == SSSC_J_TWO) ||
       ((cfg_width >= SSSC_J_MIN) && (cfg_width <= SSSC_J_MAX)));
  end

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [2:0] meta;
  logic [2:0] sync;
  logic lclk_d;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= 3'h0;
      sync <= 3'h0;
      lclk_d <= 1'b0;
    end else begin
      meta <= {align_bypass, rx_data_pin, rx_link_clk};
      sync <= meta;
      lclk_d <= sync[0];
    end
  end
  logic lclk_rise;
  logic lclk_fall;
  assign lclk_rise = sync[0] & ~lclk_d;
  assign lclk_fall = ~sync[0] & lclk_d;

  // ****************************************************************
  // Sampling phase generator
  // ****************************************************************
  logic [5:0] ph_cnt;
  logic [5:0] next_ph_cnt;
  logic samp;
  // [R2] Multiply link clock by mult
  always_comb begin
    next_ph_cnt = ph_cnt;
    samp = 1'b0;
    if (lclk_rise) begin
      next_ph_cnt = SSSC_W_MIN;
      samp = 1'b1;
    end else if (ph_cnt != 6'h00 && ph_cnt < mult) begin
      next_ph_cnt = ph_cnt + SSSC_W_MIN;
      samp = 1'b1;
    end else if (ph_cnt >= mult) begin
      next_ph_cnt = 6'h00;
    end
    // [R5] Double rate sampling on both edges
    if (width == SSSC_J_TWO && lclk_fall) begin
      samp = 1'b1;
    end
  end

  // ****************************************************************
  // Phase alignment unit
  // ****************************************************************
  logic [SSSC_PH_N-1:0] dhist;
  logic [1:0] phase;
  logic [1:0] next_phase;
  logic [3:0] hits;
  logic [3:0] next_hits;
  sssc_align_t al_st;
  sssc_align_t next_al_st;
  logic dsel;
  // [R6] Phase detection and selection
  always_comb begin
    next_phase = phase;
    next_hits = hits;
    next_al_st = al_st;
    case (al_st)
      SSSC_AL_IDLE: begin
        next_hits = 4'h0;
        if (!sync[2]) begin
          next_al_st = SSSC_AL_HUNT;
        end
      end
      SSSC_AL_HUNT: begin
        if (samp) begin
          if (dhist[phase] == dhist[phase + 2'h1]) begin
            next_hits = hits + 4'h1;
          end else begin
            next_phase = phase + 2'h1;
            next_hits = 4'h0;
          end
        end
        if (hits == SSSC_ALIGN_HITS) begin
          next_al_st = SSSC_AL_LOCK;
        end
      end
      SSSC_AL_LOCK: begin
        next_hits = hits;
      end
      default: begin
        next_al_st = SSSC_AL_IDLE;
      end
    endcase
    // [R8] Run time switch to bypass
    if (sync[2]) begin
      next_al_st = SSSC_AL_IDLE;
      next_phase = SSSC_PH_RST;
    end
  end
  // [R7] Bypass uses current sample
  assign dsel = sync[2] ? sync[1] : dhist[phase];

  // ****************************************************************
  // Deserializer
  // ****************************************************************
  logic [SSSC_MAXW-1:0] shreg;
  logic [SSSC_MAXW-1:0] next_shreg;
  logic [3:0] bcnt;
  logic [3:0] next_bcnt;
  logic word_done;
  // [R4] Same framing for all widths
  always_comb begin
    next_shreg = shreg;
    next_bcnt = bcnt;
    word_done = 1'b0;
    if (samp && cfg_ok) begin
      next_shreg = {shreg[SSSC_MAXW-2:0], dsel};
      // [R5] Width one ends a word on every sample
      if (bcnt + 4'h1 >= width) begin
        next_bcnt = 4'h0;
        word_done = 1'b1;
      end else begin
        next_bcnt = bcnt + 4'h1;
      end
    end
  end

  // ****************************************************************
  // Synchroniser buffer and realigner
  // ****************************************************************
  logic [SSSC_FIFO_AW:0] wp;
  logic [SSSC_FIFO_AW:0] rp;
  logic [SSSC_FIFO_AW:0] next_wp;
  logic [SSSC_FIFO_AW:0] next_rp;
  logic rd_pend;
  logic next_rd_pend;
  logic [SSSC_MAXW-1:0] mem_q;
  logic [SSSC_MAXW-1:0] aligned;
  logic fifo_full;
  // [R9] Pointer based elastic buffer
  always_comb begin
    fifo_full = (wp[SSSC_FIFO_AW] != rp[SSSC_FIFO_AW]) &&
      (wp[SSSC_FIFO_AW-1:0] == rp[SSSC_FIFO_AW-1:0]);
    next_wp = (word_done && !fifo_full) ? wp + 3'h1 : wp;
    next_rp = (wp != rp) ? rp + 3'h1 : rp;
    next_rd_pend = (wp != rp);
  end
  sssc_fifo_mem u_mem (
    .clk_sys(clk_sys),
    .wr_en(word_done && !fifo_full),
    .wr_addr(wp[SSSC_FIFO_AW-1:0]),
    .wr_data(next_shreg),
    .rd_addr(rp[SSSC_FIFO_AW-1:0]),
    .rd_data(mem_q)
  );
  // [R6] Realign word to low bits
  always_comb begin
    aligned = '0;
    for (int i = 0; i < SSSC_MAXW; i++) begin
      if (i < width) begin
        aligned[i] = mem_q[i];
      end
    end
  end

  // ****************************************************************
  // Serializer
  // ****************************************************************
  logic [SSSC_MAXW-1:0] txsh;
  logic [SSSC_MAXW-1:0] next_txsh;
  logic [3:0] tcnt;
  logic [3:0] next_tcnt;
  logic next_tx_ready;
  logic next_tx_clk;
  logic next_tx_dat;
  // [R1] Data with forwarded clock
  always_comb begin
    next_txsh = txsh;
    next_tcnt = tcnt;
    next_tx_clk = ~tx_link_clk;
    next_tx_dat = tx_data_pin;
    next_tx_ready = 1'b0;
    if (tx_valid && tx_ready) begin
      next_txsh = tx_word;
      next_tcnt = width;
    end else if (tx_link_clk) begin
      if (tcnt == 4'h0) begin
        next_tx_ready = cfg_ok;
      end else begin
        next_tx_dat = txsh[tcnt - 4'h1];
        next_tcnt = tcnt - 4'h1;
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      width <= SSSC_J_RST;
      mult <= SSSC_W_RST;
      ph_cnt <= 6'h00;
      dhist <= '0;
      phase <= SSSC_PH_RST;
      hits <= 4'h0;
      al_st <= SSSC_AL_IDLE;
      shreg <= '0;
      bcnt <= 4'h0;
      wp <= '0;
      rp <= '0;
      rd_pend <= 1'b0;
      rx_word <= '0;
      rx_valid <= 1'b0;
      rx_locked <= 1'b0;
      cfg_error <= 1'b0;
      txsh <= '0;
      tcnt <= 4'h0;
      tx_ready <= 1'b0;
      tx_link_clk <= 1'b0;
      tx_data_pin <= 1'b0;
    end else begin
      width <= cfg_width;
      mult <= cfg_mult;
      ph_cnt <= next_ph_cnt;
      dhist <= samp ? {dhist[SSSC_PH_N-2:0], sync[1]} : dhist;
      phase <= next_phase;
      hits <= next_hits;
      al_st <= next_al_st;
      shreg <= next_shreg;
      bcnt <= next_bcnt;
      wp <= next_wp;
      rp <= next_rp;
      rd_pend <= next_rd_pend;
      rx_word <= rd_pend ? aligned : rx_word;
      rx_valid <= rd_pend;
      rx_locked <= (al_st == SSSC_AL_LOCK) || sync[2];
      cfg_error <= ~cfg_ok;
      txsh <= next_txsh;
      tcnt <= next_tcnt;
      tx_ready <= next_tx_ready;
      tx_link_clk <= next_tx_clk;
      tx_data_pin <= next_tx_dat;
    end
  end

endmodule

// >>> logic/sssc_fifo_mem.sv
`timescale 1ns/100ps
module sssc_fifo_mem
  import sssc_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Write side
  input wire logic wr_en,
  input wire logic [SSSC_FIFO_AW-1:0] wr_addr,
  input wire logic [SSSC_MAXW-1:0] wr_data,
  // Read side
  input wire logic [SSSC_FIFO_AW-1:0] rd_addr,
  output logic [SSSC_MAXW-1:0] rd_data
);

  logic [SSSC_MAXW-1:0] mem [SSSC_FIFO_DEPTH];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

// >>> logic/sssc_pkg.sv
package sssc_pkg;

  // ****************************************************************
  // Widths and factor ranges
  // ****************************************************************
  localparam int unsigned SSSC_MAXW = 10;
  localparam logic [3:0] SSSC_J_MIN = 4'h4;
  localparam logic [3:0] SSSC_J_MAX = 4'hA;
  localparam logic [3:0] SSSC_J_ONE = 4'h1;
  localparam logic [3:0] SSSC_J_TWO = 4'h2;
  localparam logic [5:0] SSSC_W_MIN = 6'h01;
  localparam logic [5:0] SSSC_W_MAX = 6'h20;
  localparam logic [3:0] SSSC_J_RST = 4'hA;
  localparam logic [5:0] SSSC_W_RST = 6'h01;

  // ****************************************************************
  // Elastic buffer
  // ****************************************************************
  localparam int unsigned SSSC_FIFO_AW = 2;
  localparam int unsigned SSSC_FIFO_DEPTH = 4;

  // ****************************************************************
  // Phase alignment
  // ****************************************************************
  localparam int unsigned SSSC_PH_N = 4;
  localparam logic [1:0] SSSC_PH_RST = 2'h0;
  localparam logic [3:0] SSSC_ALIGN_HITS = 4'h8;

  typedef enum logic [2:0] {
    SSSC_AL_IDLE = 3'b001,
    SSSC_AL_HUNT = 3'b010,
    SSSC_AL_LOCK = 3'b100
  } sssc_align_t;

endpackage
